// *** src/usp_pkg.sv ***
package usp_pkg;

  // Register indices on the bus; printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is four times it.
  localparam logic [7:0] USP_IDX_CTRL1  = 8'h1A;
  localparam logic [7:0] USP_IDX_CTRL2  = 8'h1B;
  localparam logic [7:0] USP_IDX_BAUD   = 8'h1C;
  localparam logic [7:0] USP_IDX_STATUS = 8'h1D;
  localparam logic [7:0] USP_IDX_DATA   = 8'h1E;
  localparam logic [7:0] USP_IDX_POFF   = 8'h1F;
  localparam int         USP_ADDR_W     = 10;

  // Control one fields.
  localparam int USP_C1_TXEN  = 7;
  localparam int USP_C1_RXEN  = 6;
  localparam int USP_C1_TSTOP = 5;
  localparam int USP_C1_EVEN  = 4;
  localparam int USP_C1_PAREN = 3;
  localparam int USP_C1_IRSEL = 2;
  localparam int USP_C1_BCLK  = 1;

  // Control two fields.
  localparam int USP_C2_RTS_LO = 3;
  localparam int USP_C2_NR_LO  = 1;
  localparam int USP_C2_RSTOP  = 0;

  // Status fields.
  localparam int USP_SR_PARITY_ERROR_FLAG = 7;
  localparam int USP_SR_FRAMING_ERROR_FLAG = 6;
  localparam int USP_SR_OVERRUN_ERROR_FLAG = 5;
  localparam int USP_SR_RBSY = 3;
  localparam int USP_SR_RECEIVE_BUFFER_FULL_FLAG = 2;
  localparam int USP_SR_TBSY = 1;
  localparam int USP_SR_TRANSMIT_BUFFER_FULL_FLAG = 0;

  // Power-off control field.
  localparam int USP_POFF_EN = 0;

  localparam logic [7:0] USP_RESET_VAL = 8'h00;
  localparam logic [3:0] USP_BITS_MIN  = 4'hF;

endpackage : usp_pkg

// *** src/usp_uart.sv ***
`timescale 1ns/10ps
module usp_uart
  import usp_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic [USP_ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              stop_mode,
  input  wire logic              idle_zero_mode,
  input  wire logic              sleep_zero_mode,
  input  wire logic              system_out_en,
  input  wire logic              rxd_in,
  input  wire logic              tca_tick,
  output logic                   txd_out,
  output logic                   txd_oe,
  output logic                   transmit_interrupt_request,
  output logic                   receive_interrupt_request
);

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {USP_IDLE, USP_START, USP_SHIFT, USP_STOP} usp_state_t;

  logic [7:0]        serial_control_one;
  logic [7:0]        serial_control_two;
  logic [7:0]        baud_divisor_reg;
  logic              port_clock_enable;
  logic              parity_error_flag;
  logic              framing_error_flag;
  logic              overrun_error_flag;
  logic              receive_buffer_full_flag;
  logic              transmit_buffer_full_flag;
  logic [DATA_W-1:0] serial_receive_buffer;
  logic [DATA_W-1:0] serial_transmit_buffer;
  usp_state_t        tx_state;
  usp_state_t        rx_state;
  logic [7:0]        tx_div;
  logic [7:0]        rx_div;
  logic [3:0]        tx_rt;
  logic [3:0]        rx_rt;
  logic [3:0]        tx_bit;
  logic [3:0]        rx_bit;
  logic [DATA_W:0]   tx_shift;
  logic [DATA_W:0]   rx_shift;
  logic              tx_line;
  logic              rx_prev;
  logic              ack_pending;
  logic [7:0]        status;

  wire low_power  = stop_mode | idle_zero_mode | sleep_zero_mode;
  // The port clock is modelled as a state enable; gating the real clock is left to the chip.
  wire port_run   = clk_en & port_clock_enable & ~low_power;
  wire tx_busy    = (tx_state != USP_IDLE);
  wire rx_busy    = (rx_state != USP_IDLE);
  wire [7:0] idx  = avs_address[USP_ADDR_W-1:2];
  wire wr_low     = avs_write & avs_byteenable[0] & clk_en;
  wire rd_fire    = avs_read & clk_en & ~ack_pending;
  wire tx_lock    = serial_control_one[USP_C1_TXEN] | tx_busy;
  wire rx_lock    = serial_control_one[USP_C1_RXEN] | rx_busy;
  wire [7:0] wd   = avs_writedata[7:0];

  function automatic logic [3:0] usp_rt_len(input logic [2:0] sel, input logic odd);
    unique case (sel)
      3'h1:    usp_rt_len = odd ? 4'hF : 4'h0;
      3'h2:    usp_rt_len = 4'hE;
      3'h3:    usp_rt_len = odd ? 4'hE : 4'hF;
      3'h4:    usp_rt_len = 4'h0;
      default: usp_rt_len = 4'hF;
    endcase
  endfunction : usp_rt_len

  function automatic logic [3:0] usp_frame_bits(input logic par, input logic two);
    usp_frame_bits = 4'h9 + {3'h0, par} + {3'h0, two};
  endfunction : usp_frame_bits

  // One RT tick: divisor expired, or the timer tick when that base clock is selected.
  function automatic logic usp_tick(input logic [7:0] cnt, input logic bsel, input logic tca);
    usp_tick = bsel ? tca : (cnt == 8'h00);
  endfunction : usp_tick

  wire tx_rt_tick = usp_tick(tx_div, serial_control_one[USP_C1_BCLK], tca_tick);
  wire rx_rt_tick = usp_tick(rx_div, serial_control_one[USP_C1_BCLK], tca_tick);
  // Bit counters hold zero on the start bit, which is frame bit one, an odd bit.
  wire [3:0] tx_rt_last = usp_rt_len(serial_control_two[5:3], ~tx_bit[0]);
  wire [3:0] rx_rt_last = usp_rt_len(serial_control_two[5:3], ~rx_bit[0]);
  wire tx_bit_end = tx_rt_tick & (tx_rt == tx_rt_last);
  wire rx_bit_end = rx_rt_tick & (rx_rt == rx_rt_last);
  wire rx_mid     = rx_rt_tick & (rx_rt == 4'h7);
  wire [3:0] tx_nbits = usp_frame_bits(serial_control_one[USP_C1_PAREN],
                                       serial_control_one[USP_C1_TSTOP]);
  wire [3:0] rx_nbits = usp_frame_bits(serial_control_one[USP_C1_PAREN],
                                       serial_control_two[USP_C2_RSTOP]);
  wire tx_take    = port_run & (tx_state == USP_IDLE) & serial_control_one[USP_C1_TXEN]
                    & transmit_buffer_full_flag;

  //////////////////////////////////////////////////////////////////////////////
  // Read data comes from a register, so each read waits one cycle; writes never wait.
  always_comb begin
    avs_waitrequest = avs_read & ~ack_pending;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ack_pending <= 1'b0;
    end else if (clk_en) begin
      ack_pending <= avs_read & ~ack_pending;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_fire) begin
      unique case (idx)
        USP_IDX_CTRL1:  avs_readdata <= {24'h0, serial_control_one[7:1], 1'b0};
        USP_IDX_CTRL2:  avs_readdata <= {24'h0, 2'b00, serial_control_two[5:0]};
        USP_IDX_BAUD:   avs_readdata <= {24'h0, baud_divisor_reg};
        USP_IDX_STATUS: avs_readdata <= {24'h0, status};
        USP_IDX_DATA:   avs_readdata <= {24'h0, serial_receive_buffer};
        USP_IDX_POFF:   avs_readdata <= {24'h0, 7'h00, port_clock_enable};
        default:        avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    status              = 8'h00;
    status[USP_SR_PARITY_ERROR_FLAG] = parity_error_flag;
    status[USP_SR_FRAMING_ERROR_FLAG] = framing_error_flag;
    status[USP_SR_OVERRUN_ERROR_FLAG] = overrun_error_flag;
    status[USP_SR_RBSY] = rx_busy;
    status[USP_SR_RECEIVE_BUFFER_FULL_FLAG] = receive_buffer_full_flag;
    status[USP_SR_TBSY] = tx_busy;
    status[USP_SR_TRANSMIT_BUFFER_FULL_FLAG] = transmit_buffer_full_flag;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      port_clock_enable <= 1'b0;
    end else if (wr_low && idx == USP_IDX_POFF) begin
      port_clock_enable <= wd[USP_POFF_EN];
    end
  end

  // Control writes need the port clock, so they are gated by it like all port state except the low-power clears.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      serial_control_one <= USP_RESET_VAL;
    end else if (clk_en && low_power) begin
      serial_control_one[USP_C1_TXEN] <= 1'b0;
      serial_control_one[USP_C1_RXEN] <= 1'b0;
    end else if (clk_en && port_clock_enable && wr_low && idx == USP_IDX_CTRL1) begin
      serial_control_one[USP_C1_TXEN] <= wd[USP_C1_TXEN];
      serial_control_one[USP_C1_RXEN] <= wd[USP_C1_RXEN];
      if (!tx_lock) begin
        serial_control_one[USP_C1_TSTOP] <= wd[USP_C1_TSTOP];
        serial_control_one[USP_C1_IRSEL] <= wd[USP_C1_IRSEL];
      end
      if (!tx_lock && !rx_lock) begin
        serial_control_one[USP_C1_EVEN]  <= wd[USP_C1_EVEN];
        serial_control_one[USP_C1_PAREN] <= wd[USP_C1_PAREN];
        serial_control_one[USP_C1_BCLK]  <= wd[USP_C1_BCLK];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      serial_control_two <= USP_RESET_VAL;
    end else if (port_run && wr_low && idx == USP_IDX_CTRL2) begin
      if (!tx_lock && !rx_lock) begin
        serial_control_two[5:3] <= wd[5:3];
      end
      if (!rx_lock) begin
        serial_control_two[2:1] <= wd[2:1];
        serial_control_two[USP_C2_RSTOP] <= wd[USP_C2_RSTOP];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      baud_divisor_reg <= USP_RESET_VAL;
    end else if (port_run && wr_low && idx == USP_IDX_BAUD) begin
      baud_divisor_reg <= wd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit buffer; contents are left as they are on low-power entry (undefined to software).
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      serial_transmit_buffer <= '0;
    end else if (port_run && wr_low && idx == USP_IDX_DATA) begin
      serial_transmit_buffer <= wd[DATA_W-1:0];
    end
  end

  // A write landing on the edge after the take, where the request clears the flag, wins, so a new byte is not lost.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      transmit_buffer_full_flag  <= 1'b0;
      transmit_interrupt_request <= 1'b0;
    end else if (clk_en && low_power) begin
      transmit_buffer_full_flag  <= 1'b0;
      transmit_interrupt_request <= 1'b0;
    end else if (port_run) begin
      transmit_interrupt_request <= tx_take;
      if (wr_low && idx == USP_IDX_DATA) begin
        transmit_buffer_full_flag <= 1'b1;
      end else if (transmit_interrupt_request) begin
        transmit_buffer_full_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tx_state <= USP_IDLE;
      tx_div   <= 8'h00;
      tx_rt    <= 4'h0;
      tx_bit   <= 4'h0;
      tx_shift <= '1;
      tx_line  <= 1'b1;
    end else if (clk_en && low_power) begin
      tx_state <= USP_IDLE;
      tx_line  <= 1'b1;
    end else if (port_run) begin
      tx_div <= (tx_div == 8'h00) ? baud_divisor_reg : tx_div - 8'h01;
      if (tx_rt_tick) begin
        tx_rt <= (tx_rt == tx_rt_last) ? 4'h0 : tx_rt + 4'h1;
      end
      unique case (tx_state)
        USP_IDLE: begin
          tx_line <= 1'b1;
          if (tx_take) begin
            tx_shift <= {~^serial_transmit_buffer ^ serial_control_one[USP_C1_EVEN],
                         serial_transmit_buffer};
            tx_state <= USP_SHIFT;
            tx_bit   <= 4'h0;
            tx_rt    <= 4'h0;
            tx_div   <= baud_divisor_reg;
            tx_line  <= 1'b0;
          end
        end
        USP_SHIFT, USP_START, USP_STOP: begin
          if (tx_bit_end) begin
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == tx_nbits) begin
              tx_state <= USP_IDLE;
              tx_line  <= 1'b1;
            end else if (tx_bit >= 4'h8 + {3'h0, serial_control_one[USP_C1_PAREN]}) begin
              tx_line <= 1'b1;
            end else begin
              tx_line  <= tx_shift[0];
              tx_shift <= {1'b1, tx_shift[DATA_W:1]};
            end
          end
        end
      endcase
    end
  end

  // Infrared shaping is outside this block; the select only fixes the level driven in low power.
  always_comb begin
    txd_oe  = 1'b1;
    txd_out = tx_line;
    if (low_power) begin
      txd_out = ~serial_control_one[USP_C1_IRSEL];
      if (stop_mode && !system_out_en) begin
        txd_oe = 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rx_state <= USP_IDLE;
      rx_div   <= 8'h00;
      rx_rt    <= 4'h0;
      rx_bit   <= 4'h0;
      rx_shift <= '0;
      rx_prev  <= 1'b1;
    end else if (clk_en && low_power) begin
      rx_state <= USP_IDLE;
      rx_prev  <= 1'b1;
    end else if (port_run) begin
      rx_prev <= rxd_in;
      rx_div  <= (rx_div == 8'h00) ? baud_divisor_reg : rx_div - 8'h01;
      if (rx_rt_tick) begin
        rx_rt <= (rx_rt == rx_rt_last) ? 4'h0 : rx_rt + 4'h1;
      end
      unique case (rx_state)
        USP_IDLE: begin
          if (serial_control_one[USP_C1_RXEN] && rx_prev && !rxd_in) begin
            rx_state <= USP_START;
            rx_bit   <= 4'h0;
            rx_rt    <= 4'h0;
            rx_div   <= baud_divisor_reg;
          end
        end
        USP_START, USP_SHIFT, USP_STOP: begin
          if (rx_mid) begin
            if (rx_state == USP_START) begin
              rx_state <= rxd_in ? USP_IDLE : USP_SHIFT;
            end else if (rx_bit <= 4'h8 + {3'h0, serial_control_one[USP_C1_PAREN]}) begin
              rx_shift <= {rxd_in, rx_shift[DATA_W:1]};
            end
            if (rx_bit == rx_nbits) begin
              rx_state <= USP_IDLE;
            end
          end
          if (rx_bit_end) begin
            rx_bit <= rx_bit + 4'h1;
          end
        end
      endcase
    end
  end

  // Frame end is the mid-sample of the last stop bit; errors are judged there.
  wire rx_done    = port_run & rx_mid & (rx_state != USP_START) & (rx_state != USP_IDLE)
                    & (rx_bit == rx_nbits);
  wire [DATA_W-1:0] rx_data = serial_control_one[USP_C1_PAREN] ? rx_shift[DATA_W-1:0]
                                                               : rx_shift[DATA_W:1];
  wire rx_par_bad = serial_control_one[USP_C1_PAREN]
                    & ((^rx_shift ^ serial_control_one[USP_C1_EVEN]) == 1'b0);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      serial_receive_buffer    <= '0;
      receive_buffer_full_flag <= 1'b0;
      parity_error_flag        <= 1'b0;
      framing_error_flag       <= 1'b0;
      overrun_error_flag       <= 1'b0;
      receive_interrupt_request <= 1'b0;
    end else if (clk_en && low_power) begin
      receive_buffer_full_flag <= 1'b0;
      parity_error_flag        <= 1'b0;
      framing_error_flag       <= 1'b0;
      overrun_error_flag       <= 1'b0;
      receive_interrupt_request <= 1'b0;
    end else if (port_run) begin
      receive_interrupt_request <= rx_done;
      if (rx_done) begin
        // Overrun keeps the unread byte and drops the new one.
        if (receive_buffer_full_flag && !(rd_fire && idx == USP_IDX_DATA)) begin
          overrun_error_flag <= 1'b1;
        end else begin
          serial_receive_buffer    <= rx_data;
          receive_buffer_full_flag <= 1'b1;
          parity_error_flag        <= rx_par_bad;
          framing_error_flag       <= ~rxd_in;
        end
      end else if (rd_fire && idx == USP_IDX_DATA) begin
        receive_buffer_full_flag <= 1'b0;
        parity_error_flag        <= 1'b0;
        framing_error_flag       <= 1'b0;
        overrun_error_flag       <= 1'b0;
      end
    end
  end

endmodule : usp_uart

// *** testbench/usp_uart_checker.sv ***
`timescale 1ns/10ps
module usp_uart_checker
  import usp_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic                  ref_clk,
  input wire logic                  reset_n,
  input wire logic                  clk_en,
  input wire logic [USP_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  stop_mode,
  input wire logic                  idle_zero_mode,
  input wire logic                  sleep_zero_mode,
  input wire logic                  system_out_en,
  input wire logic                  rxd_in,
  input wire logic                  tca_tick,
  input wire logic                  txd_out,
  input wire logic                  txd_oe,
  input wire logic                  transmit_interrupt_request,
  input wire logic                  receive_interrupt_request
);
  logic lp;
  logic st_rd;
  assign lp    = stop_mode | idle_zero_mode | sleep_zero_mode;
  assign st_rd = avs_read & clk_en & avs_waitrequest
                 & (avs_address[USP_ADDR_W-1:2] == USP_IDX_STATUS);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////
  property p_no_wait; avs_write |-> !avs_waitrequest; endproperty
  a_no_wait: assert property (p_no_wait) else $error("write held off");
  property p_rd_wait; avs_read && avs_waitrequest && clk_en |=> !avs_waitrequest; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read never answered");
  property p_stat_rd; st_rd |=> avs_readdata[4] == 1'h0 && avs_readdata[31:8] == 24'h0; endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status spare bit set");
  // One cycle of margin lets the mode flush the status before it is sampled.
  property p_lp_stat; lp && $past(lp) && st_rd |=> avs_readdata[7:0] == 8'h00; endproperty
  a_lp_stat: assert property (p_lp_stat) else $error("status kept in low power");
  property p_lp_halt; lp && $past(lp) |-> !transmit_interrupt_request; endproperty
  a_lp_halt: assert property (p_lp_halt) else $error("port ran in low power");
  property p_float; (stop_mode && !system_out_en) [*2] |-> !txd_oe; endproperty
  a_float: assert property (p_float) else $error("line driven in stop");
  property p_drive; (!stop_mode || system_out_en) [*2] |-> txd_oe; endproperty
  a_drive: assert property (p_drive) else $error("line not driven");
  property p_tx_start; transmit_interrupt_request |-> !txd_out [*8]; endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit after take");
  property p_tx_pulse; transmit_interrupt_request |=> !transmit_interrupt_request; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("long tx request");
  property p_rx_pulse; receive_interrupt_request |=> !receive_interrupt_request; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("long rx request");
  c_tx: cover property (transmit_interrupt_request);
  c_rx: cover property (receive_interrupt_request);
  c_float: cover property (stop_mode && !txd_oe);
endmodule : usp_uart_checker

bind usp_uart usp_uart_checker #(.DATA_W(DATA_W)) usp_uart_checker_inst (
  .ref_clk, .reset_n, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .stop_mode, .idle_zero_mode,
  .sleep_zero_mode, .system_out_en, .rxd_in, .tca_tick, .txd_out, .txd_oe,
  .transmit_interrupt_request, .receive_interrupt_request);

// *** testbench/usp_uart_partner.sv ***
`timescale 1ns/10ps
module usp_uart_partner #(
  parameter int BIT_CYC = 16
) (
  input  wire logic ref_clk,
  input  wire logic txd_line,
  output logic      rxd
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial rxd = 1'h1;
  //////////////////////////////////////////////////////////////////////////////
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (BIT_CYC) @(posedge ref_clk);
  endtask : bit_out
  // A wrong parity or stop level is sent only when the bench asks for it.
  task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic sb);
    bit_out(1'h0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (pe) bit_out(pb);
    bit_out(sb);
    bit_out(1'h1);
  endtask : send
  // Samples mid-bit; trailing parity or stop bits are skipped, not checked.
  always begin
    @(negedge txd_line);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    if (!txd_line) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge ref_clk);
        sh[i] = txd_line;
      end
      rx_q.push_back(sh);
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  end
endmodule : usp_uart_partner

// *** testbench/usp_uart_tb.sv ***
`timescale 1ns/10ps
module usp_uart_tb
  import usp_pkg::*;
;
  logic                  ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [USP_ADDR_W-1:0] avs_address;
  logic [31:0]           avs_writedata, avs_readdata;
  logic                  stop_mode, idle_zero_mode, sleep_zero_mode, system_out_en;
  logic                  rxd_in, txd_out, txd_oe;
  logic                  transmit_interrupt_request, receive_interrupt_request;
  wire                   txd_line = txd_oe ? txd_out : 1'h1;
  int                    miscompares = 0, n_tests = 0, cyc = 0;
  logic [7:0]            c1, c2, v, w, d, st;
  usp_uart usp_uart_inst (.ref_clk, .reset_n, .clk_en(1'h1), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .stop_mode, .idle_zero_mode, .sleep_zero_mode, .system_out_en, .rxd_in, .tca_tick(1'h0),
    .txd_out, .txd_oe, .transmit_interrupt_request, .receive_interrupt_request);
  usp_uart_partner usp_uart_partner_inst (.ref_clk, .txd_line, .rxd(rxd_in));
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    avs_address   <= {idx, 2'h0};
    avs_writedata <= {24'h0, dat};
    avs_write     <= 1'h1;
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    avs_write <= 1'h0;
    @(posedge ref_clk);
  endtask : wr
  // Read data is taken at the edge where waitrequest is seen low, then the read drops.
  task automatic rchk(input logic [7:0] idx, input logic [7:0] msk, input logic [7:0] exp);
    avs_address <= {idx, 2'h0};
    avs_read    <= 1'h1;
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    st = avs_readdata[7:0];
    avs_read <= 1'h0;
    @(posedge ref_clk);
    chk(st & msk, exp);
  endtask : rchk
  function automatic logic [7:0] c1_exp(input logic [7:0] o, input logic [7:0] n);
    c1_exp = {n[7:6], o[7] ? o[5] : n[5], |o[7:6] ? o[4:3] : n[4:3], o[7] ? o[2] : n[2],
              |o[7:6] ? o[1] : n[1], 1'h0};
  endfunction : c1_exp
  function automatic logic [7:0] c2_exp(input logic [7:0] o, input logic [7:0] n,
                                        input logic [7:0] k);
    c2_exp = {2'h0, |k[7:6] ? o[5:3] : n[5:3], k[6] ? o[2:0] : n[2:0]};
  endfunction : c2_exp
  task automatic rx_case(input logic [7:0] cfg, input logic bp, input logic bs,
                         input logic [7:0] ev);
    d = 8'($urandom);
    wr(USP_IDX_CTRL1, 8'h00);
    wr(USP_IDX_CTRL1, cfg);
    wr(USP_IDX_CTRL1, cfg | 8'hC0);
    fork
      usp_uart_partner_inst.send(d, cfg[3], (cfg[4] ? ^d : ~^d) ^ bp, ~bs);
      begin
        repeat (60) @(posedge ref_clk);
        rchk(USP_IDX_STATUS, 8'h0F, 8'h08);
      end
    join
    repeat (20) @(posedge ref_clk);
    rchk(USP_IDX_STATUS, (ev == 8'h04) ? 8'hE4 : 8'hE0, ev);
    rchk(USP_IDX_DATA, (ev == 8'h04) ? 8'hFF : 8'h00, (ev == 8'h04) ? d : 8'h00);
    rchk(USP_IDX_STATUS, 8'hFF, 8'h00);
  endtask : rx_case
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(87));
    {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {stop_mode, idle_zero_mode, sleep_zero_mode} = 3'h0;
    system_out_en = 1'h1;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    rchk(USP_IDX_POFF, 8'h01, 8'h00);
    wr(USP_IDX_CTRL1, 8'h24);
    wr(USP_IDX_POFF, 8'h01);
    rchk(USP_IDX_CTRL1, 8'hFF, 8'h00);
    rchk(USP_IDX_STATUS, 8'hFF, 8'h00);
    rchk(USP_IDX_DATA, 8'hFF, 8'h00);
    {c1, c2} = 16'h0;
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom);
      w = 8'($urandom);
      wr(USP_IDX_CTRL1, v);
      c1 = c1_exp(c1, v);
      rchk(USP_IDX_CTRL1, 8'hFF, c1);
      wr(USP_IDX_CTRL2, w);
      c2 = c2_exp(c2, w, c1);
      rchk(USP_IDX_CTRL2, 8'hFF, c2);
      wr(USP_IDX_STATUS, w);
      rchk(USP_IDX_STATUS, 8'hFF, 8'h00);
      wr(8'h00, v);
      rchk(8'h00, 8'hFF, 8'h00);
    end
    wr(USP_IDX_CTRL1, 8'h00);
    wr(USP_IDX_CTRL1, 8'h00);
    wr(USP_IDX_CTRL2, 8'h00);
    wr(USP_IDX_BAUD, 8'h00);
    wr(USP_IDX_POFF, 8'h00);
    wr(USP_IDX_CTRL1, 8'h24);
    wr(USP_IDX_POFF, 8'h01);
    rchk(USP_IDX_CTRL1, 8'hFF, 8'h00);
    rx_case(8'h00, 1'h0, 1'h0, 8'h04);
    rx_case(8'h18, 1'h0, 1'h0, 8'h04);
    rx_case(8'h08, 1'h0, 1'h0, 8'h04);
    rx_case(8'h18, 1'h1, 1'h0, 8'h80);
    rx_case(8'h08, 1'h1, 1'h0, 8'h80);
    rx_case(8'h00, 1'h0, 1'h1, 8'h40);
    // A second frame before the first is read must not replace it.
    w = 8'($urandom);
    usp_uart_partner_inst.send(d, 1'h0, 1'h0, 1'h1);
    usp_uart_partner_inst.send(w, 1'h0, 1'h0, 1'h1);
    repeat (20) @(posedge ref_clk);
    rchk(USP_IDX_STATUS, 8'hE4, 8'h24);
    rchk(USP_IDX_DATA, 8'hFF, d);
    wr(USP_IDX_CTRL1, 8'h00);
    d = 8'($urandom);
    w = 8'($urandom);
    wr(USP_IDX_DATA, d);
    rchk(USP_IDX_STATUS, 8'hFF, 8'h01);
    wr(USP_IDX_CTRL1, 8'h80);
    repeat (4) @(posedge ref_clk);
    rchk(USP_IDX_STATUS, 8'hFF, 8'h02);
    wr(USP_IDX_DATA, w);
    rchk(USP_IDX_STATUS, 8'hFF, 8'h03);
    for (int i = 0; i < 600 && usp_uart_partner_inst.rx_q.size() < 2; i++) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
    rchk(USP_IDX_STATUS, 8'hFF, 8'h00);
    chk(usp_uart_partner_inst.rx_q.size() == 2 ? usp_uart_partner_inst.rx_q[0] : ~d, d);
    chk(usp_uart_partner_inst.rx_q.size() == 2 ? usp_uart_partner_inst.rx_q[1] : ~w, w);
    v = 8'($urandom) & 8'h24;
    wr(USP_IDX_CTRL1, 8'h00);
    wr(USP_IDX_CTRL1, v);
    wr(USP_IDX_CTRL1, v | 8'h80);
    wr(USP_IDX_DATA, d);
    for (int i = 0; i < 50 && !transmit_interrupt_request; i++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    stop_mode     <= 1'h1;
    system_out_en <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk({7'h0, txd_oe}, 8'h00);
    rchk(USP_IDX_STATUS, 8'hFF, 8'h00);
    rchk(USP_IDX_CTRL1, 8'hFF, v);
    rchk(USP_IDX_BAUD, 8'hFF, 8'h00);
    stop_mode     <= 1'h0;
    system_out_en <= 1'h1;
    repeat (200) @(posedge ref_clk);
    usp_uart_partner_inst.rx_q.delete();
    for (int i = 0; i < 4; i++) begin
      wr(USP_IDX_CTRL1, {5'h0, i[0], 2'h0});
      idle_zero_mode  <= (i == 0);
      sleep_zero_mode <= (i == 1);
      stop_mode       <= i[1];
      repeat (3) @(posedge ref_clk);
      chk({6'h0, txd_oe, txd_out}, {6'h0, 1'h1, ~i[0]});
      {idle_zero_mode, sleep_zero_mode, stop_mode} <= 3'h0;
      @(posedge ref_clk);
    end
    summarize();
  end
endmodule : usp_uart_tb
